// file: hw/codec_ctl.sv
// Codec control top: AHB-Lite registers, mode logic, soft mute ramp
`timescale 1ns/10ps
module codec_ctl
  import codec_ctl_pkg::*;
#(
  parameter int STEP_CYCLES = RAMP_STEP_CYCLES
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic CE,
  input wire logic HSEL,
  input wire logic [31:0] HADDR,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic [2:0] HSIZE,
  input wire logic [31:0] HWDATA,
  input wire logic HREADY,
  output logic [31:0] HRDATA,
  output logic HREADYOUT,
  output logic HRESP,
  input wire logic SAMPLE_STROBE,
  input wire logic [LEVEL_W-1:0] ADC_LEVEL,
  output logic [GAIN_W-1:0] PREAMP_GAIN,
  output logic [GAIN_W-1:0] BOOST_GAIN,
  output logic [7:0] DAC_ATTEN,
  output logic DAC_ZERO,
  output logic ADC_RUN,
  output logic DAC_RUN,
  output logic REF_RUN,
  output logic SLEEP,
  output logic [PART_COUNT-1:0] PART_DOWN,
  output logic IRQ
);
  typedef enum logic [3:0] {
    M_UNMUTED = 4'b0001,
    M_DOWN = 4'b0010,
    M_MUTED = 4'b0100,
    M_UP = 4'b1000
  } mute_e;

  typedef struct packed {
    logic [31:0] cfg1;
    logic [31:0] cfg2;
    logic [31:0] cfg3;
    logic [31:0] lim;
    logic mute;
    logic [31:0] pmr;
    logic [1:0] irq_mask;
    logic [1:0] irq_flag;
    logic [31:0] manual;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
    mute_e mstate;
    logic [7:0] atten;
    logic [31:0] step_cnt;
    logic [GAIN_W-1:0] pre;
    logic [GAIN_W-1:0] boost;
    logic zero;
    logic adc_run;
    logic dac_run;
    logic ref_run;
    logic sleep;
    logic [PART_COUNT-1:0] part_down;
    logic irq;
  } top_s;
  top_s cur, next_cur;

  logic [GAIN_W-1:0] agc_gain;
  logic agc_run;
  logic [1:0] ev;

  function automatic logic [31:0] rd_mux(input logic [7:0] a, input top_s s);
    case (a)
      OFS_AUTO_GAIN_CFG_1: rd_mux = s.cfg1;
      OFS_AUTO_GAIN_CFG_2: rd_mux = s.cfg2;
      OFS_AUTO_GAIN_CFG_3: rd_mux = s.cfg3;
      OFS_AUTO_GAIN_LIMITS: rd_mux = s.lim;
      OFS_CODEC_CONTROL_1: rd_mux = {31'h0, s.mute};
      OFS_POWER_MODE_CTRL_2: rd_mux = s.pmr;
      OFS_IRQ_CONTROL: rd_mux = {30'h0, s.irq_mask};
      OFS_IRQ_FLAGS: rd_mux = {30'h0, s.irq_flag};
      OFS_STATUS: rd_mux = {20'h0, s.atten, s.mstate};
      OFS_MANUAL_GAIN: rd_mux = s.manual;
      default: rd_mux = 32'h0000_0000;
    endcase
  endfunction

  // Standby freezes the gain engine as well as the analog paths
  assign agc_run = cur.cfg1[CFG1_ENABLE_BIT] && !cur.pmr[PMR_STANDBY_BIT];

  agc_core #(.GW(GAIN_W), .LW(LEVEL_W)) u_agc (
    .clk(CLK),
    .rst_n(RESETN),
    .ce(CE),
    .run(agc_run),
    .sample(SAMPLE_STROBE),
    .level(ADC_LEVEL),
    .target(cur.cfg1[CFG1_TARGET_LSB +: LEVEL_W]),
    .window(cur.cfg1[CFG1_WINDOW_LSB +: LEVEL_W]),
    .crit(cur.cfg3[CFG3_CRIT_LSB +: LEVEL_W]),
    .gate_thr(cur.cfg2[CFG2_NOISE_GATE_THRESHOLD_LSB +: LEVEL_W]),
    .gate_en(cur.cfg2[CFG2_NOISE_GATE_ENABLE_BIT]),
    .hold(cur.cfg2[CFG2_HOLD_LSB +: 16]),
    .rise_rate(cur.cfg3[CFG3_RISE_LSB +: 8]),
    .fall_rate(cur.cfg3[CFG3_FALL_LSB +: 8]),
    .upper(cur.lim[LIM_UPPER_LSB +: GAIN_W]),
    .lower(cur.lim[LIM_LOWER_LSB +: GAIN_W]),
    .gain(agc_gain)
  );

  always_comb begin
    next_cur = cur;
    ev = 2'b00;
    // Write data phase lands one cycle after the address phase
    if (cur.wr_pend) begin
      next_cur.wr_pend = 1'b0;
      case (cur.wr_addr)
        OFS_AUTO_GAIN_CFG_1: next_cur.cfg1 = HWDATA;
        OFS_AUTO_GAIN_CFG_2: next_cur.cfg2 = HWDATA;
        OFS_AUTO_GAIN_CFG_3: next_cur.cfg3 = HWDATA;
        OFS_AUTO_GAIN_LIMITS: next_cur.lim = HWDATA;
        OFS_CODEC_CONTROL_1: next_cur.mute = HWDATA[CTL1_MUTE_BIT];
        OFS_POWER_MODE_CTRL_2: next_cur.pmr = HWDATA;
        OFS_IRQ_CONTROL: next_cur.irq_mask = HWDATA[1:0];
        OFS_IRQ_FLAGS: next_cur.irq_flag = cur.irq_flag & ~HWDATA[1:0];
        OFS_MANUAL_GAIN: next_cur.manual = HWDATA;
        default: next_cur.manual = cur.manual;
      endcase
    end
    if (HSEL && HREADY && HTRANS[1]) begin
      next_cur.wr_pend = HWRITE;
      next_cur.wr_addr = HADDR[7:0];
      next_cur.rdata = HWRITE ? 32'h0000_0000 : rd_mux(HADDR[7:0], cur);
    end
    // Soft mute ramp; standby during a ramp is not supported
    if (cur.step_cnt != 32'h0) next_cur.step_cnt = cur.step_cnt - 32'h1;
    case (cur.mstate)
      M_UNMUTED: begin
        if (cur.mute) begin
          next_cur.mstate = M_DOWN;
          next_cur.step_cnt = STEP_CYCLES;
          next_cur.zero = 1'b0;
        end
      end
      M_DOWN: begin
        if (cur.step_cnt == 32'h0) begin
          next_cur.step_cnt = STEP_CYCLES;
          if (cur.atten == 8'hFF) begin
            next_cur.mstate = M_MUTED;
            next_cur.zero = 1'b1;
            ev[IRQ_DOWN_BIT] = 1'b1;
          end else begin
            next_cur.atten = cur.atten + 8'h01;
          end
        end
      end
      M_MUTED: begin
        if (!cur.mute) begin
          next_cur.mstate = M_UP;
          next_cur.step_cnt = STEP_CYCLES;
          next_cur.zero = 1'b0;
        end
      end
      M_UP: begin
        if (cur.step_cnt == 32'h0) begin
          next_cur.step_cnt = STEP_CYCLES;
          if (cur.atten == 8'h00) begin
            next_cur.mstate = M_UNMUTED;
            ev[IRQ_UP_BIT] = 1'b1;
          end else begin
            next_cur.atten = cur.atten - 8'h01;
          end
        end
      end
      default: next_cur.mstate = M_UNMUTED;
    endcase
    // Set wins over a clearing write in the same cycle
    next_cur.irq_flag = next_cur.irq_flag | ev;
    next_cur.irq = |(next_cur.irq_flag & ~cur.irq_mask);
    // Power modes
    next_cur.ref_run = !cur.pmr[PMR_STANDBY_BIT];
    next_cur.sleep = cur.pmr[PMR_SLEEP_BIT] && !cur.pmr[PMR_STANDBY_BIT];
    next_cur.adc_run = !cur.pmr[PMR_STANDBY_BIT] && !cur.pmr[PMR_SLEEP_BIT];
    next_cur.dac_run = !cur.pmr[PMR_STANDBY_BIT] && !cur.pmr[PMR_SLEEP_BIT];
    next_cur.part_down = cur.pmr[PMR_PARTS_LSB +: PART_COUNT];
    if (agc_run) begin
      next_cur.pre = agc_gain;
      next_cur.boost = agc_gain;
    end else begin
      next_cur.pre = cur.manual[0 +: GAIN_W];
      next_cur.boost = cur.manual[8 +: GAIN_W];
    end
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      cur <= '0;
      cur.cfg1 <= RST_CFG1;
      cur.cfg2 <= RST_CFG2;
      cur.cfg3 <= RST_CFG3;
      cur.lim <= RST_LIM;
      cur.pmr <= RST_PMR;
      cur.manual <= RST_MANUAL;
      cur.mute <= 1'b1;
      cur.mstate <= M_MUTED;
      cur.atten <= 8'hFF;
      cur.zero <= 1'b1;
      cur.part_down <= '1;
    end else if (CE) begin
      cur <= next_cur;
    end
  end

  assign HRDATA = cur.rdata;
  assign HREADYOUT = 1'b1;
  assign HRESP = 1'b0;
  assign PREAMP_GAIN = cur.pre;
  assign BOOST_GAIN = cur.boost;
  assign DAC_ATTEN = cur.atten;
  assign DAC_ZERO = cur.zero;
  assign ADC_RUN = cur.adc_run;
  assign DAC_RUN = cur.dac_run;
  assign REF_RUN = cur.ref_run;
  assign SLEEP = cur.sleep;
  assign PART_DOWN = cur.part_down;
  assign IRQ = cur.irq;

  standby_stop_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && cur.pmr[PMR_STANDBY_BIT] |=> !REF_RUN && !ADC_RUN && !DAC_RUN)
    else $error("standby left paths running");
  muted_zero_a: assert property (@(posedge CLK) disable iff (!RESETN)
    cur.mstate == M_MUTED |-> DAC_ZERO && DAC_ATTEN == 8'hFF)
    else $error("muted state without zero output");
  down_flag_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && ev[IRQ_DOWN_BIT] |=> cur.irq_flag[IRQ_DOWN_BIT])
    else $error("gain down flag not set");
  up_flag_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && cur.mstate == M_UP && next_cur.mstate == M_UNMUTED |=> cur.irq_flag[IRQ_UP_BIT])
    else $error("gain up flag not set");
  irq_mask_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> IRQ == |(cur.irq_flag & ~$past(cur.irq_mask)))
    else $error("masked interrupt raised");
  sleep_mode_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && cur.pmr[PMR_SLEEP_BIT] && !cur.pmr[PMR_STANDBY_BIT] |=> SLEEP && !DAC_RUN)
    else $error("sleep bit ignored");
  parts_down_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE |=> PART_DOWN == $past(cur.pmr[PMR_PARTS_LSB +: PART_COUNT]))
    else $error("stand-by input mismatch");
  manual_gain_a: assert property (@(posedge CLK) disable iff (!RESETN)
    CE && !agc_run |=> PREAMP_GAIN == $past(cur.manual[0 +: GAIN_W]))
    else $error("manual gain not applied");
endmodule

// file: hw/codec_ctl_pkg.sv
// Constants and register map for the codec control block
// What this block does
// - Auto gain moves preamp and boost gain toward the target level.
// - Combined gain stays within upper and lower limit fields.
// - A hold interval from the hold field delays adjustment after enable and after each critical drop.
// - Level below target after hold: raise gain one step, decay rate.
// - Level above target after hold: lower gain one step, attack rate.
// - Noise gate enabled blocks gain increase below gate threshold.
// - Above critical threshold gain drops fast, no hold wait.
// - Level inside target window leaves gain unchanged.
// - Level below noise boundary is noise; no adjustment.
// - Reset is asynchronous active low, held at least one clock.
// - Leaving reset the codec enters standby.
// - Global standby stops ADC, DAC and references; clearing leaves it.
// - Mute ramps DAC gain to minus infinity, then output is zero.
// - Gain-down done sets flag; interrupt only when mask bit is 0.
// - Unmute ramps gain back to 0dB, sets gain-up flag, interrupt.
// - Each gain ramp lasts about 17 to 18 milliseconds.
// - Twelve stand-by inputs power down parts independently.
// - Auto gain acts only when enabled; else programmed gains apply.
package codec_ctl_pkg;
  localparam logic [7:0] OFS_AUTO_GAIN_CFG_1 = 8'h00;
  localparam logic [7:0] OFS_AUTO_GAIN_CFG_2 = 8'h04;
  localparam logic [7:0] OFS_AUTO_GAIN_CFG_3 = 8'h08;
  localparam logic [7:0] OFS_AUTO_GAIN_LIMITS = 8'h0C;
  localparam logic [7:0] OFS_CODEC_CONTROL_1 = 8'h10;
  localparam logic [7:0] OFS_POWER_MODE_CTRL_2 = 8'h14;
  localparam logic [7:0] OFS_IRQ_CONTROL = 8'h18;
  localparam logic [7:0] OFS_IRQ_FLAGS = 8'h1C;
  localparam logic [7:0] OFS_STATUS = 8'h20;
  localparam logic [7:0] OFS_MANUAL_GAIN = 8'h24;
  // Field positions
  localparam int CFG1_TARGET_LSB = 0;
  localparam int CFG1_WINDOW_LSB = 8;
  localparam int CFG1_ENABLE_BIT = 31;
  localparam int CFG2_HOLD_LSB = 0;
  localparam int CFG2_NOISE_GATE_THRESHOLD_LSB = 16;
  localparam int CFG2_NOISE_GATE_ENABLE_BIT = 31;
  localparam int CFG3_RISE_LSB = 0;
  localparam int CFG3_FALL_LSB = 8;
  localparam int CFG3_CRIT_LSB = 16;
  localparam int LIM_UPPER_LSB = 0;
  localparam int LIM_LOWER_LSB = 8;
  localparam int CTL1_MUTE_BIT = 0;
  localparam int PMR_STANDBY_BIT = 0;
  localparam int PMR_SLEEP_BIT = 1;
  localparam int PMR_PARTS_LSB = 4;
  localparam int IRQ_DOWN_BIT = 0;
  localparam int IRQ_UP_BIT = 1;
  // Reset values
  localparam logic [31:0] RST_CFG1 = 32'h0000_0460;
  localparam logic [31:0] RST_CFG2 = 32'h0008_0100;
  localparam logic [31:0] RST_CFG3 = 32'h0078_0404;
  localparam logic [31:0] RST_LIM = 32'h0000_001F;
  localparam logic [31:0] RST_PMR = 32'h0000_FFF3;
  localparam logic [31:0] RST_MANUAL = 32'h0000_0000;
  // Ramp timing
  localparam int CLK_MHZ = 250;
  localparam int RAMP_TIME_US = 17500;
  localparam int RAMP_STEPS = 256;
  localparam int RAMP_STEP_CYCLES = (RAMP_TIME_US * CLK_MHZ) / RAMP_STEPS;
  localparam int GAIN_W = 6;
  localparam int LEVEL_W = 8;
  localparam int PART_COUNT = 12;
endpackage

// file: hw/agc_core.sv
// Automatic gain step engine, one decision per sample
`timescale 1ns/10ps
module agc_core
  import codec_ctl_pkg::*;
#(
  parameter int GW = GAIN_W,
  parameter int LW = LEVEL_W
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic run,
  input wire logic sample,
  input wire logic [LW-1:0] level,
  input wire logic [LW-1:0] target,
  input wire logic [LW-1:0] window,
  input wire logic [LW-1:0] crit,
  input wire logic [LW-1:0] gate_thr,
  input wire logic gate_en,
  input wire logic [15:0] hold,
  input wire logic [7:0] rise_rate,
  input wire logic [7:0] fall_rate,
  input wire logic [GW-1:0] upper,
  input wire logic [GW-1:0] lower,
  output logic [GW-1:0] gain
);
  typedef struct packed {
    logic [GW-1:0] gain;
    logic [15:0] hold_cnt;
    logic [7:0] rate_cnt;
  } agc_s;
  agc_s cur, next_cur;
  logic lo_edge, hi_edge;

  always_comb begin
    next_cur = cur;
    // Nine-bit sums so a loud level or a high target cannot wrap
    lo_edge = ({1'b0, level} + {1'b0, window}) < {1'b0, target};
    hi_edge = {1'b0, level} > ({1'b0, target} + {1'b0, window});
    if (!run) begin
      next_cur.hold_cnt = hold;
      next_cur.rate_cnt = '0;
      if (cur.gain > upper) next_cur.gain = upper;
      else if (cur.gain < lower) next_cur.gain = lower;
    end else if (sample) begin
      if (level > crit) begin
        if (cur.gain > lower) next_cur.gain = cur.gain - 1'b1;
        next_cur.hold_cnt = hold;
      end else if (cur.hold_cnt != 16'h0000) begin
        next_cur.hold_cnt = cur.hold_cnt - 16'h0001;
      end else if (gate_en && level < gate_thr) begin
        next_cur.rate_cnt = '0;
      end else if (!lo_edge && !hi_edge) begin
        next_cur.rate_cnt = '0;
      end else if (cur.rate_cnt != 8'h00) begin
        next_cur.rate_cnt = cur.rate_cnt - 8'h01;
      end else if (lo_edge) begin
        if (cur.gain < upper) next_cur.gain = cur.gain + 1'b1;
        next_cur.rate_cnt = rise_rate;
      end else begin
        if (cur.gain > lower) next_cur.gain = cur.gain - 1'b1;
        next_cur.rate_cnt = fall_rate;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) cur <= '0;
    else if (ce) cur <= next_cur;
  end

  assign gain = cur.gain;

  gain_floor_a: assert property (@(posedge clk) disable iff (!rst_n)
    run && $past(run) && lower <= upper && $stable(lower) |-> gain >= lower || $past(gain) < lower)
    else $error("auto gain under lower limit");
  crit_drop_a: assert property (@(posedge clk) disable iff (!rst_n)
    ce && run && sample && level > crit && gain > lower && gain <= upper |=> gain == $past(gain) - 1)
    else $error("critical level did not lower gain");
endmodule

// file: verif/tb.sv
// Self-checking bench for the codec control block
`timescale 1ns/10ps
module tb;
  import codec_ctl_pkg::*;
  localparam int STEP = 2;
  logic clk;
  logic resetn;
  logic hsel;
  logic [31:0] haddr;
  logic [1:0] htrans;
  logic hwrite;
  logic [2:0] hsize;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hreadyout;
  logic hresp;
  logic sample;
  logic [LEVEL_W-1:0] level;
  logic [GAIN_W-1:0] preamp_gain;
  logic [GAIN_W-1:0] boost_gain;
  logic [7:0] dac_atten;
  logic dac_zero, adc_run, dac_run, ref_run, sleep_out, irq;
  logic [PART_COUNT-1:0] part_down;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [31:0] rd;

  codec_ctl #(.STEP_CYCLES(STEP)) i_dut (.CLK(clk), .RESETN(resetn), .CE(1'b1), .HSEL(hsel),
    .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
    .HREADY(hreadyout), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
    .SAMPLE_STROBE(sample), .ADC_LEVEL(level), .PREAMP_GAIN(preamp_gain),
    .BOOST_GAIN(boost_gain), .DAC_ATTEN(dac_atten), .DAC_ZERO(dac_zero), .ADC_RUN(adc_run),
    .DAC_RUN(dac_run), .REF_RUN(ref_run), .SLEEP(sleep_out), .PART_DOWN(part_down),
    .IRQ(irq));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  always @(posedge clk) cyc <= cyc + 1;

  task automatic final_report();
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  // Bounded wait; the slave answers at once but no latency is assumed
  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1, "hready stuck");
  endtask

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'h2;
    hwrite <= wr;
    hsize <= 3'h2;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
    rd = hrdata;
    chk({31'h0, hresp}, 32'h0, "response");
  endtask

  task automatic wr32(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
    repeat (2) @(posedge clk);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, "register read");
  endtask

  task automatic send(input logic [7:0] lv, input int n);
    for (int i = 0; i < n; i++) begin
      sample <= 1'b1;
      level <= lv;
      @(posedge clk);
      sample <= 1'b0;
      repeat (3) @(posedge clk);
    end
    repeat (3) @(posedge clk);
  endtask

  task automatic reset_values();
    chk({31'h0, dac_zero}, 32'h1, "mute output at reset");
    chk({20'h0, part_down}, 32'h0000_0FFF, "parts at reset");
    chk({29'h0, adc_run, dac_run, ref_run}, 32'h0, "standby after reset");
    rd_chk(OFS_AUTO_GAIN_CFG_1, RST_CFG1);
    rd_chk(OFS_AUTO_GAIN_CFG_2, RST_CFG2);
    rd_chk(OFS_AUTO_GAIN_CFG_3, RST_CFG3);
    rd_chk(OFS_AUTO_GAIN_LIMITS, RST_LIM);
    rd_chk(OFS_POWER_MODE_CTRL_2, RST_PMR);
    rd_chk(OFS_MANUAL_GAIN, RST_MANUAL);
    rd_chk(OFS_CODEC_CONTROL_1, 32'h1);
    rd_chk(8'hF0, 32'h0);
  endtask

  task automatic power_modes();
    wr32(OFS_POWER_MODE_CTRL_2, 32'h0);
    chk({28'h0, adc_run, dac_run, ref_run, sleep_out}, 32'hE, "running");
    chk({20'h0, part_down}, 32'h0, "parts up");
    wr32(OFS_POWER_MODE_CTRL_2, 32'h0000_A5A2);
    chk({31'h0, sleep_out}, 32'h1, "sleep entered");
    chk({20'h0, part_down}, 32'h0000_0A5A, "parts pattern");
    wr32(OFS_POWER_MODE_CTRL_2, 32'h0000_0001);
    chk({29'h0, adc_run, dac_run, ref_run}, 32'h0, "standby stops paths");
    wr32(OFS_POWER_MODE_CTRL_2, 32'h0);
    chk({31'h0, sleep_out}, 32'h0, "sleep left");
  endtask

  // Polls the flag register; returns cycles taken
  task automatic ramp(input logic mute, input int bitn, output int dur);
    int t0;
    int n;
    t0 = cyc;
    wr32(OFS_CODEC_CONTROL_1, {31'h0, mute});
    n = 0;
    do begin
      bus(1'b0, OFS_IRQ_FLAGS, 32'h0);
      n++;
    end while (rd[bitn] !== 1'b1 && n < 1000);
    dur = cyc - t0;
  endtask

  task automatic soft_mute();
    int dur;
    wr32(OFS_IRQ_CONTROL, 32'h0);
    ramp(1'b0, IRQ_UP_BIT, dur);
    // Poll granularity is a few cycles, so the window is loose
    chk({31'h0, dur > 256 * STEP && dur < 256 * (STEP + 1) + 60}, 32'h1, "ramp time");
    chk({24'h0, dac_atten}, 32'h0, "gain back at 0dB");
    chk({31'h0, dac_zero}, 32'h0, "output live");
    chk({31'h0, irq}, 32'h1, "up irq unmasked");
    wr32(OFS_IRQ_FLAGS, 32'h2);
    chk({31'h0, irq}, 32'h0, "irq cleared");
    wr32(OFS_IRQ_CONTROL, 32'h1);
    ramp(1'b1, IRQ_DOWN_BIT, dur);
    chk({24'h0, dac_atten}, 32'hFF, "gain at minus infinity");
    chk({31'h0, dac_zero}, 32'h1, "output zero");
    chk({31'h0, irq}, 32'h0, "down irq masked");
    rd_chk(OFS_IRQ_FLAGS, 32'h1);
    wr32(OFS_IRQ_FLAGS, 32'h1);
    rd_chk(OFS_IRQ_FLAGS, 32'h0);
  endtask

  task automatic auto_gain();
    wr32(OFS_AUTO_GAIN_LIMITS, 32'h0000_031F);
    wr32(OFS_AUTO_GAIN_CFG_2, 32'h8008_0001);
    wr32(OFS_AUTO_GAIN_CFG_3, 32'h0078_0101);
    wr32(OFS_AUTO_GAIN_CFG_1, 32'h8000_0460);
    send(8'h30, 200);
    chk({26'h0, preamp_gain}, 32'h1F, "rise to upper");
    chk({26'h0, boost_gain}, 32'h1F, "boost follows");
    send(8'h62, 20);
    chk({26'h0, preamp_gain}, 32'h1F, "window holds");
    // Long hold: once a critical drop reloads it, only the critical path may move the gain
    wr32(OFS_AUTO_GAIN_CFG_2, 32'h8008_0100);
    send(8'hF0, 5);
    chk({31'h0, preamp_gain <= 6'h1C && preamp_gain >= 6'h1A}, 32'h1, "fast drop");
    wr32(OFS_AUTO_GAIN_CFG_2, 32'h8008_0001);
    // Critical drop reloaded the long hold; a disable cycle reloads the short one
    wr32(OFS_AUTO_GAIN_CFG_1, 32'h0000_0460);
    wr32(OFS_AUTO_GAIN_CFG_1, 32'h8000_0460);
    send(8'h70, 200);
    chk({26'h0, preamp_gain}, 32'h03, "fall to lower");
    send(8'h04, 30);
    chk({26'h0, preamp_gain}, 32'h03, "noise gate");
    wr32(OFS_AUTO_GAIN_CFG_1, 32'h0000_0460);
    wr32(OFS_MANUAL_GAIN, 32'h0000_0A05);
    chk({26'h0, preamp_gain}, 32'h05, "manual preamp");
    chk({26'h0, boost_gain}, 32'h0A, "manual boost");
  endtask

  initial begin
    resetn = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    sample = 1'b0;
    level = 8'h00;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    @(posedge clk);
    reset_values();
    power_modes();
    soft_mute();
    auto_gain();
    // Ramps are idle here, so standby is legal before power goes
    wr32(OFS_POWER_MODE_CTRL_2, 32'h0000_FFF3);
    chk({29'h0, adc_run, dac_run, ref_run}, 32'h0, "complete standby");
    final_report();
  end

  // Run needs roughly 4k cycles
  initial begin
    #400000;
    mismatches++;
    final_report();
  end
endmodule
